// ### logic/hci_policy.sv
// Host CPU interface policy core
`timescale 1ns/10ps
module hci_policy (
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_rst_n,
   // Configuration port
   input  wire logic [7:0]  i_cfg_addr,
   input  wire logic        i_cfg_wr,
   input  wire logic [7:0]  i_cfg_wdata,
   output logic      [7:0]  o_cfg_rdata,
   // Strap pins
   input  wire logic [2:0]  i_strap_freq,
   // Downstream CPU cycle
   input  wire logic        i_cyc_valid,
   input  wire logic [2:0]  i_cyc_kind,
   input  wire logic        i_cyc_dram,
   input  wire logic        i_cyc_ext_cfg,
   output logic             o_cyc_ready,
   output logic             o_resp_valid,
   output logic      [1:0]  o_resp_code,
   // Write queue and read state
   input  wire logic [3:0]  i_wq_count,
   input  wire logic        i_wq_full,
   input  wire logic        i_rd_busy,
   output logic             o_flush_writes,
   output logic             o_strict_order,
   // Speculative read
   input  wire logic        i_rd_req,
   input  wire logic        i_rdq_empty,
   input  wire logic        i_snoop_done,
   input  wire logic        i_snoop_hit,
   output logic             o_spec_issue,
   output logic             o_spec_discard,
   // Arbitration requests
   input  wire logic        i_cpu_req,
   input  wire logic        i_up_req,
   output logic             o_grant_cpu,
   output logic             o_grant_up,
   // DRAM request path
   input  wire logic        i_dram_valid,
   input  wire logic        i_dram_8qw,
   input  wire logic        i_dram_up,
   input  wire logic        i_dram_up_hi,
   input  wire logic        i_dram_pair,
   input  wire logic        i_conv_phase,
   output logic             o_dram_ready,
   output logic             o_dram_req,
   output logic             o_dram_len8,
   output logic             o_dram_second,
   output logic             o_dram_hi_prio
);
   typedef enum logic {HCI_SPLIT_IDLE, HCI_SPLIT_SECOND} hci_split_t;

   logic [7:0] reg_basic;
   logic [7:0] cpu_interface_advanced;
   logic [7:0] dram_arbitration_timers;
   logic [7:0] host_misc_control_one;
   logic [7:0] host_misc_control_two;
   logic [7:0] reg_policy_one;
   logic [7:0] reg_policy_two;
   logic [2:0] freq_field;
   logic [2:0] strap_s1;
   logic [2:0] strap_s2;
   logic [2:0] strap_s3;
   logic       strap_taken;
   logic [1:0] strap_fill;

   logic       io_write_retry_select;
   logic       defer_enable;
   logic       read_around_write_enable;
   logic       resp_pipe;
   logic       hi_prio_en;
   logic       retire_policy_one_enable;
   logic       retire_policy_two_enable;
   logic [1:0] spec_mode;
   logic       burst_en;
   logic       merge_en;
   logic       conv_sync;
   logic [3:0] medium_retire_threshold;
   logic [3:0] high_retire_threshold;
   logic [3:0] low_retire_threshold;

   assign io_write_retry_select    = reg_basic[hci_pkg::BIT_IO_WR_RETRY];
   assign defer_enable             = reg_basic[hci_pkg::BIT_DEFER_EN];
   assign read_around_write_enable = reg_basic[hci_pkg::BIT_RAW_EN];
   assign resp_pipe                = cpu_interface_advanced[hci_pkg::BIT_RESP_PIPE];
   assign hi_prio_en               = cpu_interface_advanced[hci_pkg::BIT_HI_PRIO_EN];
   assign retire_policy_one_enable = cpu_interface_advanced[hci_pkg::BIT_POLICY_ONE];
   assign spec_mode                = cpu_interface_advanced[hci_pkg::BIT_SPEC_LSB +: 2];
   assign burst_en                 = host_misc_control_one[hci_pkg::BIT_BURST_EN];
   assign merge_en                 = host_misc_control_one[hci_pkg::BIT_MERGE_EN];
   assign conv_sync                = host_misc_control_one[hci_pkg::BIT_CONV_SYNC];
   assign retire_policy_two_enable = host_misc_control_two[hci_pkg::BIT_POLICY_TWO];
   assign medium_retire_threshold  = reg_policy_one[hci_pkg::BIT_THR_MED_LSB +: 4];
   assign high_retire_threshold    = reg_policy_two[hci_pkg::BIT_THR_HI_LSB +: 4];
   assign low_retire_threshold     = reg_policy_two[hci_pkg::BIT_THR_LO_LSB +: 4];

   // Configuration registers
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         reg_basic               <= hci_pkg::RST_BASIC;
         cpu_interface_advanced  <= hci_pkg::RST_ADVANCED;
         dram_arbitration_timers <= hci_pkg::RST_ARB_TIMERS;
         host_misc_control_one   <= hci_pkg::RST_MISC_ONE;
         host_misc_control_two   <= hci_pkg::RST_MISC_TWO;
         reg_policy_one          <= hci_pkg::RST_POLICY;
         reg_policy_two          <= hci_pkg::RST_POLICY;
      end else if (i_cfg_wr) begin
         case (i_cfg_addr)
            hci_pkg::ADDR_BASIC: begin
               reg_basic <= i_cfg_wdata;
            end
            hci_pkg::ADDR_ADVANCED: begin
               cpu_interface_advanced <= (i_cfg_wdata & ~hci_pkg::RO_MASK_ADVANCED)
                                         | (hci_pkg::RST_ADVANCED & hci_pkg::RO_MASK_ADVANCED);
            end
            hci_pkg::ADDR_ARB_TIMERS: begin
               dram_arbitration_timers <= i_cfg_wdata;
            end
            hci_pkg::ADDR_MISC_ONE: begin
               host_misc_control_one <= i_cfg_wdata & ~hci_pkg::RO_MASK_MISC_ONE;
            end
            hci_pkg::ADDR_MISC_TWO: begin
               host_misc_control_two <= (i_cfg_wdata & ~hci_pkg::RO_MASK_MISC_TWO)
                                        | (hci_pkg::RST_MISC_TWO & hci_pkg::RO_MASK_MISC_TWO);
            end
            hci_pkg::ADDR_POLICY_ONE: begin
               reg_policy_one <= i_cfg_wdata;
            end
            hci_pkg::ADDR_POLICY_TWO: begin
               reg_policy_two <= i_cfg_wdata;
            end
            default: begin
            end
         endcase
      end
   end

   // Strap synchroniser
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         strap_s1 <= 3'h0;
         strap_s2 <= 3'h0;
         strap_s3 <= 3'h0;
      end else begin
         strap_s1 <= i_strap_freq;
         strap_s2 <= strap_s1;
         strap_s3 <= strap_s2;
      end
   end

   // Strap capture once the chain holds pin values
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         freq_field  <= hci_pkg::RST_FREQ;
         strap_taken <= 1'b0;
         strap_fill  <= 2'h0;
      end else if (strap_fill != 2'h3) begin
         strap_fill <= strap_fill + 2'h1;
      end else if (!strap_taken && (strap_s2 == strap_s3)) begin
         freq_field  <= strap_s3;
         strap_taken <= 1'b1;
      end
   end

   // Register read
   always_comb begin
      case (i_cfg_addr)
         hci_pkg::ADDR_BASIC:      o_cfg_rdata = reg_basic;
         hci_pkg::ADDR_ADVANCED:   o_cfg_rdata = cpu_interface_advanced;
         hci_pkg::ADDR_ARB_TIMERS: o_cfg_rdata = dram_arbitration_timers;
         hci_pkg::ADDR_MISC_ONE:   o_cfg_rdata = {freq_field, host_misc_control_one[4:0]};
         hci_pkg::ADDR_MISC_TWO:   o_cfg_rdata = host_misc_control_two;
         hci_pkg::ADDR_POLICY_ONE: o_cfg_rdata = reg_policy_one;
         hci_pkg::ADDR_POLICY_TWO: o_cfg_rdata = reg_policy_two;
         default:                  o_cfg_rdata = 8'h00;
      endcase
   end

   // Response action decode
   hci_pkg::hci_resp_t resp_sel;
   logic               cyc_is_write;
   logic               last_valid;
   logic               last_write;

   always_comb begin
      resp_sel = hci_pkg::HCI_RESP_NORMAL;
      case (hci_pkg::hci_cyc_t'(i_cyc_kind))
         hci_pkg::HCI_CYC_LOCK_RD,
         hci_pkg::HCI_CYC_IO_RD: begin
            if (!i_cyc_dram) begin
               resp_sel = defer_enable ? hci_pkg::HCI_RESP_DEFER : hci_pkg::HCI_RESP_RETRY;
            end
         end
         hci_pkg::HCI_CYC_LOCK_WR: begin
            if (i_cyc_ext_cfg) begin
               resp_sel = io_write_retry_select ? hci_pkg::HCI_RESP_RETRY : hci_pkg::HCI_RESP_DEFER;
            end
         end
         hci_pkg::HCI_CYC_IO_WR: begin
            if (!i_cyc_dram) begin
               resp_sel = io_write_retry_select ? hci_pkg::HCI_RESP_RETRY : hci_pkg::HCI_RESP_DEFER;
            end
         end
         default: begin
            resp_sel = hci_pkg::HCI_RESP_NORMAL;
         end
      endcase
   end

   assign cyc_is_write = (i_cyc_kind == 3'(hci_pkg::HCI_CYC_MEM_WR)) || (i_cyc_kind == 3'(hci_pkg::HCI_CYC_LOCK_WR))
                         || (i_cyc_kind == 3'(hci_pkg::HCI_CYC_IO_WR));
   assign o_cyc_ready  = resp_pipe || !last_valid || (last_write == cyc_is_write);

   // Response phase register
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_resp_valid <= 1'b0;
         o_resp_code  <= 2'(hci_pkg::HCI_RESP_NORMAL);
         last_valid   <= 1'b0;
         last_write   <= 1'b0;
      end else begin
         o_resp_valid <= i_cyc_valid && o_cyc_ready;
         last_valid   <= i_cyc_valid && o_cyc_ready;
         if (i_cyc_valid && o_cyc_ready) begin
            o_resp_code <= 2'(resp_sel);
            last_write  <= cyc_is_write;
         end
      end
   end

   // Write retire policy
   logic       flush_active;
   logic [4:0] wq_level;
   logic [4:0] start_level;
   logic [4:0] stop_level;

   assign wq_level    = {1'b0, i_wq_count};
   assign start_level = retire_policy_two_enable ? 5'({1'b0, medium_retire_threshold} + 5'h01)
                                                 : 5'({1'b0, high_retire_threshold} + 5'h01);
   assign stop_level  = 5'({1'b0, low_retire_threshold} + 5'h01);

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flush_active <= 1'b0;
      end else if (!retire_policy_one_enable || !i_rd_busy) begin
         flush_active <= 1'b0;
      end else if (!flush_active && (wq_level >= start_level)) begin
         flush_active <= 1'b1;
      end else if (flush_active && (wq_level <= stop_level)) begin
         flush_active <= 1'b0;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_flush_writes <= 1'b0;
         o_strict_order <= 1'b1;
      end else begin
         o_strict_order <= !read_around_write_enable;
         if (!read_around_write_enable || !i_rd_busy) begin
            o_flush_writes <= (i_wq_count != 4'h0);
         end else if (!retire_policy_one_enable) begin
            o_flush_writes <= i_wq_full;
         end else begin
            o_flush_writes <= (flush_active || (wq_level >= start_level)) && (wq_level > stop_level);
         end
      end
   end

   // Speculative reads
   logic spec_now;
   logic spec_pending;

   assign spec_now = i_rd_req && ((spec_mode == hci_pkg::SPEC_ALL)
                     || ((spec_mode == hci_pkg::SPEC_EMPTY) && i_rdq_empty));

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_spec_issue   <= 1'b0;
         o_spec_discard <= 1'b0;
         spec_pending   <= 1'b0;
      end else begin
         o_spec_issue   <= spec_now;
         o_spec_discard <= spec_pending && i_snoop_done && i_snoop_hit;
         if (spec_now) begin
            spec_pending <= 1'b1;
         end else if (i_snoop_done) begin
            spec_pending <= 1'b0;
         end
      end
   end

   // Occupancy arbiter
   hci_arb_if arb_link ();

   assign arb_link.cpu_req    = i_cpu_req;
   assign arb_link.up_req     = i_up_req;
   assign arb_link.host_occ   = dram_arbitration_timers[hci_pkg::BIT_HOST_OCC_LSB +: 4];
   assign arb_link.master_occ = dram_arbitration_timers[hci_pkg::BIT_MAST_OCC_LSB +: 4];
   assign o_grant_cpu         = arb_link.grant_cpu;
   assign o_grant_up          = arb_link.grant_up;

   hci_occ_arbiter u_arbiter (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .arb        (arb_link.arb)
   );

   // DRAM request stage with 8QW split and merge
   hci_split_t split_state;
   logic       st_req;
   logic       st_len8;
   logic       st_second;
   logic       st_hi;
   logic       dl_req;
   logic       dl_len8;
   logic       dl_second;
   logic       dl_hi;
   logic       take;
   logic       whole8;
   logic       req_hi;

   assign o_dram_ready = (split_state == HCI_SPLIT_IDLE);
   assign take         = i_dram_valid && o_dram_ready;
   assign whole8       = (i_dram_8qw && burst_en) || (i_dram_up && i_dram_pair && merge_en);
   assign req_hi       = hi_prio_en && (i_wq_full || (i_dram_up && i_dram_up_hi));

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         split_state <= HCI_SPLIT_IDLE;
         st_req      <= 1'b0;
         st_len8     <= 1'b0;
         st_second   <= 1'b0;
         st_hi       <= 1'b0;
      end else begin
         case (split_state)
            HCI_SPLIT_IDLE: begin
               st_req    <= take;
               st_len8   <= take && whole8;
               st_second <= 1'b0;
               st_hi     <= take && req_hi;
               if (take && i_dram_8qw && !burst_en) begin
                  split_state <= HCI_SPLIT_SECOND;
               end
            end
            HCI_SPLIT_SECOND: begin
               st_req      <= 1'b1;
               st_len8     <= 1'b0;
               st_second   <= 1'b1;
               split_state <= HCI_SPLIT_IDLE;
            end
            default: begin
               split_state <= HCI_SPLIT_IDLE;
            end
         endcase
      end
   end

   // Synchronous conversion delay stage
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         dl_req    <= 1'b0;
         dl_len8   <= 1'b0;
         dl_second <= 1'b0;
         dl_hi     <= 1'b0;
      end else begin
         dl_req    <= st_req;
         dl_len8   <= st_len8;
         dl_second <= st_second;
         dl_hi     <= st_hi;
      end
   end

   // Transparent or delayed timing
   logic use_delay;

   assign use_delay      = conv_sync && i_conv_phase;
   assign o_dram_req     = use_delay ? dl_req : st_req;
   assign o_dram_len8    = use_delay ? dl_len8 : st_len8;
   assign o_dram_second  = use_delay ? dl_second : st_second;
   assign o_dram_hi_prio = use_delay ? dl_hi : st_hi;
endmodule // hci_policy

// ### pkg/hci_pkg.sv
// Constants and types of the host CPU interface policy block
package hci_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_BASIC      = 8'h51;
   localparam logic [7:0] ADDR_ADVANCED   = 8'h52;
   localparam logic [7:0] ADDR_ARB_TIMERS = 8'h53;
   localparam logic [7:0] ADDR_MISC_ONE   = 8'h54;
   localparam logic [7:0] ADDR_MISC_TWO   = 8'h55;
   localparam logic [7:0] ADDR_POLICY_ONE = 8'h56;
   localparam logic [7:0] ADDR_POLICY_TWO = 8'h5D;
   // Reset values
   localparam logic [7:0] RST_BASIC      = 8'h00;
   localparam logic [7:0] RST_ADVANCED   = 8'h02;
   localparam logic [7:0] RST_ARB_TIMERS = 8'h00;
   localparam logic [7:0] RST_MISC_ONE   = 8'h00;
   localparam logic [7:0] RST_MISC_TWO   = 8'h20;
   localparam logic [7:0] RST_POLICY     = 8'h00;
   localparam logic [2:0] RST_FREQ       = 3'h0;
   // Read-only bits
   localparam logic [7:0] RO_MASK_ADVANCED = 8'h20;
   localparam logic [7:0] RO_MASK_MISC_ONE = 8'hE1;
   localparam logic [7:0] RO_MASK_MISC_TWO = 8'h21;
   // Field positions
   localparam int BIT_IO_WR_RETRY  = 0;
   localparam int BIT_DEFER_EN     = 4;
   localparam int BIT_RAW_EN       = 6;
   localparam int BIT_RESP_PIPE    = 7;
   localparam int BIT_HI_PRIO_EN   = 6;
   localparam int BIT_POLICY_ONE   = 3;
   localparam int BIT_SPEC_LSB     = 0;
   localparam int BIT_HOST_OCC_LSB = 4;
   localparam int BIT_MAST_OCC_LSB = 0;
   localparam int BIT_FREQ_LSB     = 5;
   localparam int BIT_BURST_EN     = 4;
   localparam int BIT_MERGE_EN     = 2;
   localparam int BIT_CONV_SYNC    = 1;
   localparam int BIT_POLICY_TWO   = 2;
   localparam int BIT_THR_HI_LSB   = 4;
   localparam int BIT_THR_LO_LSB   = 0;
   localparam int BIT_THR_MED_LSB  = 4;
   // Speculative read codes
   localparam logic [1:0] SPEC_OFF   = 2'h0;
   localparam logic [1:0] SPEC_EMPTY = 2'h1;
   localparam logic [1:0] SPEC_ALL   = 2'h3;
   // Occupancy timer unit in host clocks
   localparam int OCC_UNIT_CLKS = 4;
   // Response phase actions
   typedef enum logic [1:0] {
      HCI_RESP_NORMAL = 2'h0,
      HCI_RESP_DEFER  = 2'h1,
      HCI_RESP_RETRY  = 2'h2
   } hci_resp_t;
   // Downstream CPU cycle kinds
   typedef enum logic [2:0] {
      HCI_CYC_MEM_RD  = 3'h0,
      HCI_CYC_LOCK_RD = 3'h1,
      HCI_CYC_IO_RD   = 3'h2,
      HCI_CYC_MEM_WR  = 3'h3,
      HCI_CYC_LOCK_WR = 3'h4,
      HCI_CYC_IO_WR   = 3'h5
   } hci_cyc_t;
endpackage

// ### pkg/hci_arb_if.sv
// Link between policy core and occupancy arbiter
`timescale 1ns/10ps
interface hci_arb_if;
   logic       cpu_req;
   logic       up_req;
   logic [3:0] host_occ;
   logic [3:0] master_occ;
   logic       grant_cpu;
   logic       grant_up;
   modport arb (input cpu_req, up_req, host_occ, master_occ, output grant_cpu, grant_up);
   modport ctl (output cpu_req, up_req, host_occ, master_occ, input grant_cpu, grant_up);
endinterface

// ### logic/hci_occ_arbiter.sv
// CPU versus upstream DRAM arbiter with occupancy timers
`timescale 1ns/10ps
module hci_occ_arbiter (
   // Clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_rst_n,
   // Arbitration link
   hci_arb_if.arb    arb
);
   logic       owner_cpu;
   logic       owner_up;
   logic       last_cpu;
   logic [5:0] occ_left;
   logic       unlimited;
   logic       expired;
   logic       next_cpu;
   logic       next_up;

   localparam int OCC_ONE = hci_pkg::OCC_UNIT_CLKS / hci_pkg::OCC_UNIT_CLKS;

   assign unlimited = owner_cpu ? (arb.host_occ == 4'h0) : (arb.master_occ == 4'h0);
   assign expired   = !unlimited && (occ_left == 6'h00);

   // Grant choice
   always_comb begin
      next_cpu = owner_cpu;
      next_up  = owner_up;
      if (!owner_cpu && !owner_up) begin
         if (arb.cpu_req && arb.up_req) begin
            next_cpu = last_cpu;
            next_up  = !last_cpu;
         end else begin
            next_cpu = arb.cpu_req;
            next_up  = arb.up_req;
         end
      end else if (owner_cpu) begin
         if (!arb.cpu_req || (expired && arb.up_req)) begin
            next_cpu = 1'b0;
            next_up  = arb.up_req;
         end
      end else begin
         if (!arb.up_req || (expired && arb.cpu_req)) begin
            next_up  = 1'b0;
            next_cpu = arb.cpu_req;
         end
      end
   end

   // Grant state
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         owner_cpu <= 1'b0;
         owner_up  <= 1'b0;
         last_cpu  <= 1'b1;
      end else begin
         owner_cpu <= next_cpu;
         owner_up  <= next_up;
         if (next_cpu || next_up) begin
            last_cpu <= next_cpu;
         end
      end
   end

   // Occupancy counter, reloaded on each new grant
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         occ_left <= 6'h00;
      end else if (next_cpu && !owner_cpu) begin
         occ_left <= 6'({arb.host_occ, 2'b00} - 6'(OCC_ONE));
      end else if (next_up && !owner_up) begin
         occ_left <= 6'({arb.master_occ, 2'b00} - 6'(OCC_ONE));
      end else if (occ_left != 6'h00) begin
         occ_left <= occ_left - 6'h01;
      end
   end

   assign arb.grant_cpu = owner_cpu;
   assign arb.grant_up  = owner_up;
endmodule // hci_occ_arbiter

// ### dv/hci_wq_model.sv
// Far-side write queue level model
`timescale 1ns/10ps
module hci_wq_model (
   input  wire logic       i_core_clk,
   input  wire logic       i_load,
   input  wire logic [3:0] i_level,
   output logic      [3:0] o_count,
   output logic            o_full
);
   logic [3:0] level = 4'h0;
   always_ff @(posedge i_core_clk) if (i_load) level <= i_level;
   assign o_count = level;
   assign o_full  = (level == 4'hC);
endmodule // hci_wq_model

// ### dv/hci_policy_assertions.sv
// Port checker of the policy block
`timescale 1ns/10ps
module hci_chk (
   input wire logic       i_core_clk, i_rst_n,
   input wire logic       i_cyc_valid, i_cyc_dram, o_cyc_ready, o_resp_valid,
   input wire logic [2:0] i_cyc_kind,
   input wire logic [1:0] o_resp_code,
   input wire logic       i_rd_req, i_snoop_done, i_snoop_hit, o_spec_issue, o_spec_discard,
   input wire logic       i_cpu_req, o_grant_cpu, o_grant_up,
   input wire logic       o_dram_req, o_dram_ready, o_dram_second, o_dram_hi_prio
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   a_resp_one_later: assert property (i_cyc_valid && o_cyc_ready |=> o_resp_valid)
      else $error("no response after take");
   a_dram_normal: assert property (i_cyc_valid && o_cyc_ready && i_cyc_dram && i_cyc_kind == 3'h0
      |=> o_resp_code == hci_pkg::HCI_RESP_NORMAL) else $error("dram read not normal");
   a_spec_cause: assert property (o_spec_issue |-> $past(i_rd_req)) else $error("stray speculation");
   a_discard_cause: assert property (o_spec_discard |-> $past(i_snoop_done && i_snoop_hit))
      else $error("stray discard");
   a_grant_excl: assert property (!(o_grant_cpu && o_grant_up)) else $error("double grant");
   a_grant_cause: assert property ($rose(o_grant_cpu) |-> $past(i_cpu_req)) else $error("grant w/o req");
   a_split_gap: assert property (o_dram_second |-> $past(o_dram_req) && !$past(o_dram_ready))
      else $error("bad split");
   a_prio_req: assert property (o_dram_hi_prio |-> o_dram_req) else $error("priority w/o req");
endmodule // hci_chk
bind hci_policy hci_chk u_chk (.*);

// ### dv/tb_top.sv
// Self-checking bench of the policy block
`timescale 1ns/10ps
module tb_top;
   logic       i_core_clk = 0, i_rst_n = 0, i_cfg_wr = 0, i_cyc_valid = 0, i_cyc_dram = 0, i_cyc_ext_cfg = 0;
   logic       i_wq_full, i_rd_busy = 0, i_rd_req = 0, i_rdq_empty = 0, i_snoop_done = 0, i_snoop_hit = 0;
   logic       i_cpu_req = 0, i_up_req = 0, i_dram_valid = 0, i_dram_8qw = 0, i_dram_up = 0, i_dram_up_hi = 0;
   logic       i_dram_pair = 0, i_conv_phase = 0, ld = 0;
   logic [7:0] i_cfg_addr = 8'h00, i_cfg_wdata = 8'h00, o_cfg_rdata;
   logic [3:0] i_wq_count, lv = 4'h0;
   logic [2:0] i_strap_freq = 3'h2, i_cyc_kind = 3'h0;
   logic [1:0] o_resp_code;
   logic       o_cyc_ready, o_resp_valid, o_flush_writes, o_strict_order, o_spec_issue, o_spec_discard;
   logic       o_grant_cpu, o_grant_up, o_dram_ready, o_dram_req, o_dram_len8, o_dram_second, o_dram_hi_prio;
   int         n_mismatch = 0, num_checks = 0;
   always #10 i_core_clk = ~i_core_clk;
   hci_policy DUT (.*);
   hci_wq_model u_wq (.i_core_clk(i_core_clk), .i_load(ld), .i_level(lv), .o_count(i_wq_count), .o_full(i_wq_full));
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic nx(input int n);
      repeat (n) @(negedge i_core_clk);
   endtask
   task automatic wr(input logic [7:0] a, d);
      nx(1);
      i_cfg_addr = a;
      i_cfg_wdata = d;
      i_cfg_wr = 1;
      nx(1);
      i_cfg_wr = 0;
   endtask
   task automatic rdc(input logic [7:0] a, e);
      nx(1);
      i_cfg_addr = a;
      #1 chk(o_cfg_rdata, e);
   endtask
   task automatic cyc(input logic [2:0] k, input logic d, input logic [1:0] e);
      int i;
      nx(1);
      i_cyc_valid = 1;
      i_cyc_kind = k;
      i_cyc_dram = d;
      #1;
      for (i = 0; i < 8 && o_cyc_ready !== 1'b1; i++) nx(1);
      if (i == 8) begin
         n_mismatch++;
         i_cyc_valid = 0;
         $display("unexpected at %0t: cycle never taken", $time);
         return;
      end
      nx(1);
      i_cyc_valid = 0;
      chk({o_resp_valid, o_resp_code}, {1'b1, e});
   endtask
   task automatic wq(input logic [3:0] n, input logic e);
      nx(1);
      ld = 1;
      lv = n;
      nx(1);
      ld = 0;
      nx(1);
      chk(o_flush_writes, e);
   endtask
   task automatic spec(input logic q, e);
      i_rdq_empty = q;
      nx(1);
      i_rd_req = 1;
      nx(1);
      i_rd_req = 0;
      chk(o_spec_issue, e);
   endtask
   initial begin
      nx(6);
      i_rst_n = 1;
      rdc(8'h52, 8'h02);
      rdc(8'h55, 8'h20);
      wr(8'h53, 8'h10);
      rdc(8'h53, 8'h10);
      wr(8'h52, 8'h20);
      rdc(8'h52, 8'h00);
      rdc(8'h60, 8'h00);
      rdc(8'h54, 8'h40);
      cyc(3'h0, 1, hci_pkg::HCI_RESP_NORMAL);
      cyc(3'h5, 0, hci_pkg::HCI_RESP_DEFER);
      cyc(3'h1, 0, hci_pkg::HCI_RESP_RETRY);
      wr(8'h51, 8'h11);
      cyc(3'h5, 0, hci_pkg::HCI_RESP_RETRY);
      cyc(3'h2, 0, hci_pkg::HCI_RESP_DEFER);
      cyc(3'h3, 1, hci_pkg::HCI_RESP_NORMAL);
      i_cyc_kind = 3'h0;
      #1 chk(o_cyc_ready, 0);
      i_cyc_ext_cfg = 1;
      cyc(3'h4, 0, hci_pkg::HCI_RESP_RETRY);
      i_cyc_ext_cfg = 0;
      wr(8'h51, 8'h00);
      wq(4'h1, 1);
      chk(o_strict_order, 1);
      wr(8'h51, 8'h40);
      i_rd_busy = 1;
      wq(4'hB, 0);
      wq(4'hC, 1);
      wr(8'h52, 8'h08);
      wr(8'h5D, 8'h51);
      wq(4'h2, 0);
      wq(4'h5, 0);
      wq(4'h6, 1);
      wq(4'h3, 1);
      wq(4'h2, 0);
      wr(8'h55, 8'h04);
      wr(8'h56, 8'h30);
      wq(4'h3, 0);
      wq(4'h4, 1);
      wr(8'h52, 8'h01);
      spec(0, 0);
      spec(1, 1);
      i_snoop_done = 1;
      i_snoop_hit = 1;
      nx(1);
      i_snoop_done = 0;
      chk(o_spec_discard, 1);
      wr(8'h52, 8'h03);
      spec(0, 1);
      i_cpu_req = 1;
      i_up_req = 1;
      nx(4);
      chk({o_grant_cpu, o_grant_up}, 2'b10);
      nx(4);
      chk({o_grant_cpu, o_grant_up}, 2'b01);
      i_dram_valid = 1;
      i_dram_8qw = 1;
      i_dram_up = 1;
      nx(1);
      i_dram_valid = 0;
      chk({o_dram_req, o_dram_ready}, 2'b10);
      nx(1);
      chk({o_dram_req, o_dram_second, o_dram_len8}, 3'b110);
      wr(8'h52, 8'h40);
      wr(8'h54, 8'h06);
      i_dram_8qw = 0;
      i_dram_pair = 1;
      i_dram_up_hi = 1;
      i_conv_phase = 1;
      i_dram_valid = 1;
      nx(1);
      i_dram_valid = 0;
      chk(o_dram_req, 0);
      nx(1);
      chk({o_dram_req, o_dram_len8, o_dram_hi_prio}, 3'b111);
      end_sim();
   end
endmodule // tb_top
